// >>> ipef_core_model.sv
`timescale 1ns/10ps
module ipef_core_model #(
	parameter int STAY = 4
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire ipef_pkg::ipef_grant_s grant,
	input wire logic ack,
	output ipef_pkg::ipef_svc_s svc
);
	int cnt;
	logic go;
	assign go = cnt == 0 && ack && grant.valid === 1'b1;
	// one routine at a time; the two spare cycles cover the grant's latency
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt <= 0;
			svc <= '0;
		end
		else
		begin
			svc.enter <= go;
			svc.vec <= go ? grant.vec : svc.vec;
			svc.leave <= cnt == 3;
			cnt <= go ? STAY + 2 : (cnt > 0 ? cnt - 1 : 0);
		end
	end
endmodule

// >>> ipef_ext_pin.sv
`timescale 1ns/10ps
module ipef_ext_pin (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic mcTick,
	input wire logic pinLevel,
	input wire logic trigEdge,
	input wire logic swWrite,
	input wire logic swValue,
	input wire logic svcClear,
	output logic flag
);

	typedef struct packed {
		logic sample;
		logic flag;
	} ipef_pin_s;

	ipef_pin_s st_ff;
	ipef_pin_s nxt_st;
	logic fall;

	// sampled once per machine cycle; high then low is a falling edge
	assign fall = mcTick & st_ff.sample & ~pinLevel;

	// level mode mirrors the inverted pin; edge mode latches, and set beats clear
	always_comb
	begin
		nxt_st = st_ff;
		if (mcTick)
			nxt_st.sample = pinLevel;
		if (!trigEdge)
			nxt_st.flag = ~pinLevel;
		else
		begin
			if (swWrite)
				nxt_st.flag = swValue;
			if (svcClear)
				nxt_st.flag = 1'h0;
			if (fall)
				nxt_st.flag = 1'h1;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_ff.sample <= ipef_pkg::EXT_SAMPLE_RESET;
			st_ff.flag <= 1'h0;
		end
		else
			st_ff <= nxt_st;
	end

	assign flag = st_ff.flag;

endmodule

// >>> ipef_mc_div.sv
`timescale 1ns/10ps
module ipef_mc_div #(
	parameter int DIV = ipef_pkg::MC_CLKS
) (
	input wire logic sys_clk,
	input wire logic resetn,
	output logic mcTick
);

	typedef struct packed {
		logic [7:0] cnt;
		logic tick;
	} ipef_div_s;

	ipef_div_s st_ff;
	ipef_div_s nxt_st;

	// one tick per machine cycle
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.tick = 1'h0;
		if (st_ff.cnt == 8'(DIV - 1))
		begin
			nxt_st.cnt = 8'h00;
			nxt_st.tick = 1'h1;
		end
		else
			nxt_st.cnt = st_ff.cnt + 8'h01;
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign mcTick = st_ff.tick;

endmodule

// >>> ipef_pkg.sv
package ipef_pkg;

	// ---------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ---------------------------------------------------------------
	localparam logic [7:0] TIMER_EXTIRQ_CONTROL_IDX = 8'h88;
	localparam logic [7:0] SOURCE_PRIO_LOW_IDX = 8'hb8;
	localparam logic [7:0] SOURCE_PRIO_HIGH_IDX = 8'hba;
	localparam logic [7:0] EXTRA_PRIO_HIGH_IDX = 8'hbb;
	localparam logic [7:0] EXTRA_PRIO_LOW_IDX = 8'hbc;

	// ---------------------------------------------------------------
	// reset values and field positions
	// ---------------------------------------------------------------
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic EXT_SAMPLE_RESET = 1'h1;
	localparam int EXT0_TRIG_BIT = 0;
	localparam int EXT0_FLAG_BIT = 1;
	localparam int EXT1_TRIG_BIT = 2;
	localparam int EXT1_FLAG_BIT = 3;
	localparam int SRC_LOW_BITS = 6;
	localparam int SRC_HIGH_BITS = 8;
	localparam int EXTRA_BITS = 3;
	localparam int CTRL_BITS = 4;

	// ---------------------------------------------------------------
	// vector numbers and counts
	// ---------------------------------------------------------------
	localparam int NUM_SRC = 11;
	localparam int NUM_LEVELS = 4;
	localparam logic [3:0] VEC_EXT0 = 4'h0;
	localparam logic [3:0] VEC_EXT1 = 4'h2;
	localparam int VEC_EXT2 = 6;
	localparam int VEC_EXT3 = 7;
	localparam int VEC_SPI = 8;
	localparam int MC_CLKS = 12;

	typedef logic [1:0] ipef_level_t;

	// service handshake from the core's interrupt sequencer
	typedef struct packed {
		logic enter;
		logic leave;
		logic [3:0] vec;
	} ipef_svc_s;

	// request offered to the core
	typedef struct packed {
		logic valid;
		logic [3:0] vec;
		ipef_level_t level;
	} ipef_grant_s;

endpackage

// >>> ipef_top.sv
// The AHB-Lite register port was decided locally.
`timescale 1ns/10ps
// Overview of operation
// - source priority low register holds six low bits, bits 7:6 reserved.
// - source priority high register holds eight high bits incl. external 3 and 2.
// - six standard sources take priority from their low and high bit pair.
// - external 2 and 3 priority uses high bits 6/7 with external low inputs.
// - extra priority low register: brown-out, wake timer, SPI low bits.
// - extra priority high register: brown-out, wake timer, SPI high bits.
// - brown-out, wake timer and SPI pair extra low with extra high bit.
// - external 1 trigger select, control bit 2: 0 level, 1 falling edge.
// - external 0 trigger select, control bit 0: 0 level, 1 falling edge.
// - hardware sets external 1 request flag, control bit 3, on its condition.
// - edge mode external 1 flag holds until software or service entry clears.
// - level mode external 1 flag equals inverted pin, never latched.
// - hardware sets external 0 request flag, control bit 1, on its condition.
// - edge mode external 0 flag holds until software or service entry clears.
// - level mode external 0 flag tracks the inverted pin level.
// - four priority levels over eleven sources, each individually set.
// - running routine is preempted only by a strictly higher level.
// - edge mode samples once per machine cycle; source holds level a cycle.
module ipef_top #(
	parameter int MC_DIV = ipef_pkg::MC_CLKS
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic ext_irq_zero_pin,
	input wire logic ext_irq_one_pin,
	input wire logic ext2_prio_lo,
	input wire logic ext3_prio_lo,
	input wire logic [ipef_pkg::NUM_SRC-1:0] srcPending,
	input wire ipef_pkg::ipef_svc_s svc,
	output ipef_pkg::ipef_grant_s grant,
	output logic [2*ipef_pkg::NUM_SRC-1:0] srcLevels,
	output logic [ipef_pkg::NUM_LEVELS-1:0] inService
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic dpWrite;
		logic [7:0] dpIdx;
		logic [31:0] rdata;
		logic [ipef_pkg::CTRL_BITS-1:0] trig;
		logic [ipef_pkg::SRC_LOW_BITS-1:0] prioLo;
		logic [ipef_pkg::SRC_HIGH_BITS-1:0] prioHi;
		logic [ipef_pkg::EXTRA_BITS-1:0] xLo;
		logic [ipef_pkg::EXTRA_BITS-1:0] xHi;
		logic [ipef_pkg::NUM_LEVELS-1:0] inSvc;
		ipef_pkg::ipef_grant_s grant;
	} ipef_top_s;

	ipef_top_s st_ff;
	ipef_top_s nxt_st;

	logic mcTick;
	logic flag0;
	logic flag1;
	logic addrPhase;
	logic wrCtrl;
	logic clr0;
	logic clr1;
	logic [ipef_pkg::NUM_SRC-1:0] pend;
	ipef_pkg::ipef_level_t lvl [ipef_pkg::NUM_SRC];

	// ---------------------------------------------------------------
	// machine cycle tick and external pin flags
	// ---------------------------------------------------------------

	ipef_mc_div #(
		.DIV(MC_DIV)
	) u_div (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.mcTick(mcTick)
	);

	// a control write during the data phase updates the edge-mode flags too
	assign wrCtrl = st_ff.dpWrite && (st_ff.dpIdx == ipef_pkg::TIMER_EXTIRQ_CONTROL_IDX);
	// service entry clears only the edge-latched flag of that source
	assign clr0 = svc.enter && (svc.vec == ipef_pkg::VEC_EXT0);
	assign clr1 = svc.enter && (svc.vec == ipef_pkg::VEC_EXT1);

	ipef_ext_pin u_ext0 (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.mcTick(mcTick),
		.pinLevel(ext_irq_zero_pin),
		.trigEdge(st_ff.trig[ipef_pkg::EXT0_TRIG_BIT]),
		.swWrite(wrCtrl),
		.swValue(hwdata[ipef_pkg::EXT0_FLAG_BIT]),
		.svcClear(clr0),
		.flag(flag0)
	);

	ipef_ext_pin u_ext1 (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.mcTick(mcTick),
		.pinLevel(ext_irq_one_pin),
		.trigEdge(st_ff.trig[ipef_pkg::EXT1_TRIG_BIT]),
		.swWrite(wrCtrl),
		.swValue(hwdata[ipef_pkg::EXT1_FLAG_BIT]),
		.svcClear(clr1),
		.flag(flag1)
	);

	// ---------------------------------------------------------------
	// per-source level, high bit is the msb
	// ---------------------------------------------------------------
	always_comb
	begin
		for (int i = 0; i < 6; i++)
		begin
			// vector order is ext0, t0, ext1, t1, uart, t2
			lvl[i] = {st_ff.prioHi[i], st_ff.prioLo[i]};
		end
		lvl[ipef_pkg::VEC_EXT2] = {st_ff.prioHi[6], ext2_prio_lo};
		lvl[ipef_pkg::VEC_EXT3] = {st_ff.prioHi[7], ext3_prio_lo};
		for (int i = 0; i < ipef_pkg::EXTRA_BITS; i++)
		begin
			lvl[ipef_pkg::VEC_SPI+i] = {st_ff.xHi[i], st_ff.xLo[i]};
		end
	end

	// levels leave as one flat bus, two bits a source
	always_comb
	begin
		for (int i = 0; i < ipef_pkg::NUM_SRC; i++)
		begin
			srcLevels[2*i +: 2] = lvl[i];
		end
	end

	// own flags replace the external 0/1 pending inputs
	always_comb
	begin
		pend = srcPending;
		pend[ipef_pkg::VEC_EXT0] = flag0;
		pend[ipef_pkg::VEC_EXT1] = flag1;
	end

	assign addrPhase = hsel && htrans[1] && hready;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb
	begin
		logic found;
		logic [3:0] bestVec;
		ipef_pkg::ipef_level_t bestLvl;
		logic svcAny;
		ipef_pkg::ipef_level_t svcTop;
		logic [7:0] rd;
		logic [7:0] idx;
		logic [3:0] rdFlags;
		found = 1'h0;
		bestVec = 4'h0;
		bestLvl = 2'h0;
		svcAny = 1'h0;
		svcTop = 2'h0;
		rd = 8'h00;
		idx = haddr[9:2];
		rdFlags = 4'h0;
		nxt_st = st_ff;

		// data phase write; reserved bits are dropped
		if (st_ff.dpWrite)
		begin
			unique case (st_ff.dpIdx)
				ipef_pkg::TIMER_EXTIRQ_CONTROL_IDX:
				begin
					nxt_st.trig[ipef_pkg::EXT0_TRIG_BIT] = hwdata[ipef_pkg::EXT0_TRIG_BIT];
					nxt_st.trig[ipef_pkg::EXT1_TRIG_BIT] = hwdata[ipef_pkg::EXT1_TRIG_BIT];
				end
				ipef_pkg::SOURCE_PRIO_LOW_IDX:
				begin
					nxt_st.prioLo = hwdata[ipef_pkg::SRC_LOW_BITS-1:0];
				end
				ipef_pkg::SOURCE_PRIO_HIGH_IDX:
				begin
					nxt_st.prioHi = hwdata[ipef_pkg::SRC_HIGH_BITS-1:0];
				end
				ipef_pkg::EXTRA_PRIO_HIGH_IDX:
				begin
					nxt_st.xHi = hwdata[ipef_pkg::EXTRA_BITS-1:0];
				end
				ipef_pkg::EXTRA_PRIO_LOW_IDX:
				begin
					nxt_st.xLo = hwdata[ipef_pkg::EXTRA_BITS-1:0];
				end
				default:
				begin
					nxt_st.trig = st_ff.trig;
				end
			endcase
		end

		// flags as they will stand after this edge, so a read right
		// behind a write sees the new value; the pin cells judge a
		// write by the mode that stood before it, and so must this
		rdFlags[ipef_pkg::EXT0_FLAG_BIT] = flag0;
		rdFlags[ipef_pkg::EXT1_FLAG_BIT] = flag1;
		if (wrCtrl)
		begin
			// a service entry in the same cycle still clears the flag
			if (st_ff.trig[ipef_pkg::EXT0_TRIG_BIT])
				rdFlags[ipef_pkg::EXT0_FLAG_BIT] = hwdata[ipef_pkg::EXT0_FLAG_BIT] & ~clr0;
			else
				rdFlags[ipef_pkg::EXT0_FLAG_BIT] = ~ext_irq_zero_pin;
			if (st_ff.trig[ipef_pkg::EXT1_TRIG_BIT])
				rdFlags[ipef_pkg::EXT1_FLAG_BIT] = hwdata[ipef_pkg::EXT1_FLAG_BIT] & ~clr1;
			else
				rdFlags[ipef_pkg::EXT1_FLAG_BIT] = ~ext_irq_one_pin;
		end

		// address phase: latch control and fetch read data
		// read data is caught at the address edge, so a flag set later shows next read
		nxt_st.dpWrite = 1'h0;
		if (addrPhase)
		begin
			nxt_st.dpWrite = hwrite;
			nxt_st.dpIdx = idx;
			unique case (idx)
				ipef_pkg::TIMER_EXTIRQ_CONTROL_IDX:
				begin
					rd = {4'h0, (nxt_st.trig | rdFlags)};
				end
				ipef_pkg::SOURCE_PRIO_LOW_IDX:
				begin
					rd = {2'h0, nxt_st.prioLo};
				end
				ipef_pkg::SOURCE_PRIO_HIGH_IDX:
				begin
					rd = nxt_st.prioHi;
				end
				ipef_pkg::EXTRA_PRIO_HIGH_IDX:
				begin
					rd = {5'h00, nxt_st.xHi};
				end
				ipef_pkg::EXTRA_PRIO_LOW_IDX:
				begin
					rd = {5'h00, nxt_st.xLo};
				end
				default:
				begin
					rd = ipef_pkg::REG_RESET;
				end
			endcase
			nxt_st.rdata = {24'h000000, rd};
		end

		// highest level now in service
		for (int l = 0; l < ipef_pkg::NUM_LEVELS; l++)
		begin
			if (st_ff.inSvc[l])
			begin
				svcAny = 1'h1;
				svcTop = ipef_pkg::ipef_level_t'(l);
			end
		end

		// best pending: scan levels upward, lowest vector within a level
		// a hit at a higher level overwrites, so the last hit is the winner
		for (int l = 0; l < ipef_pkg::NUM_LEVELS; l++)
		begin
			for (int i = ipef_pkg::NUM_SRC - 1; i >= 0; i--)
			begin
				if (pend[i] && (lvl[i] == ipef_pkg::ipef_level_t'(l)))
				begin
					found = 1'h1;
					bestVec = 4'(i);
					bestLvl = ipef_pkg::ipef_level_t'(l);
				end
			end
		end

		// offered only when strictly above the running routine
		// registered, so the core sees a new winner one clock after the change
		nxt_st.grant.valid = found && (!svcAny || (bestLvl > svcTop));
		nxt_st.grant.vec = bestVec;
		nxt_st.grant.level = bestLvl;

		// return drops the top routine first, then a new entry stacks
		// a vector outside the table is ignored rather than marking a level
		if (svc.leave && svcAny)
		begin
			nxt_st.inSvc[svcTop] = 1'h0;
		end
		if (svc.enter && (svc.vec < 4'(ipef_pkg::NUM_SRC)))
		begin
			nxt_st.inSvc[lvl[svc.vec]] = 1'h1;
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_ff.dpWrite <= 1'h0;
			st_ff.dpIdx <= ipef_pkg::REG_RESET;
			st_ff.rdata <= 32'h00000000;
			st_ff.trig <= ipef_pkg::REG_RESET[ipef_pkg::CTRL_BITS-1:0];
			st_ff.prioLo <= ipef_pkg::REG_RESET[ipef_pkg::SRC_LOW_BITS-1:0];
			st_ff.prioHi <= ipef_pkg::REG_RESET;
			st_ff.xLo <= ipef_pkg::REG_RESET[ipef_pkg::EXTRA_BITS-1:0];
			st_ff.xHi <= ipef_pkg::REG_RESET[ipef_pkg::EXTRA_BITS-1:0];
			st_ff.inSvc <= 4'h0;
			st_ff.grant <= '0;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	// zero wait states, always okay
	// the bus never stalls, so a master may issue transfers back to back
	assign hreadyout = 1'h1;
	assign hresp = 1'h0;
	assign hrdata = st_ff.rdata;
	assign grant = st_ff.grant;
	assign inService = st_ff.inSvc;

endmodule

// >>> ipef_top_sva.sv
`timescale 1ns/10ps
module ipef_top_sva (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic ext2_prio_lo,
	input wire logic ext3_prio_lo,
	input wire ipef_pkg::ipef_svc_s svc,
	input wire ipef_pkg::ipef_grant_s grant,
	input wire logic [2*ipef_pkg::NUM_SRC-1:0] srcLevels,
	input wire logic [3:0] inService
);
	logic rdAny_ff;
	logic rdCtl_ff;
	// marks the data phase of a read so reserved bits can be judged there
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rdAny_ff <= 1'b0;
			rdCtl_ff <= 1'b0;
		end
		else if (hready)
		begin
			rdAny_ff <= hsel && htrans[1] && !hwrite;
			rdCtl_ff <= hsel && htrans[1] && !hwrite
				&& haddr[9:2] == ipef_pkg::TIMER_EXTIRQ_CONTROL_IDX;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	chk_upper_zero: assert property (rdAny_ff |-> hrdata[31:8] == 24'h0)
		else $error("read data above the low byte not zero");
	chk_ctl_reserved: assert property (rdCtl_ff |-> hrdata[7:4] == 4'h0)
		else $error("control read shows timer bits");
	chk_ext_low: assert property (srcLevels[12] == ext2_prio_lo
		&& srcLevels[14] == ext3_prio_lo)
		else $error("external 2/3 low bit not used");
	chk_grant_vec: assert property (grant.valid |-> grant.vec < 4'hb)
		else $error("grant names no source");
	chk_grant_level: assert property (grant.valid
		|-> grant.level == 2'($past(srcLevels) >> (2 * grant.vec)))
		else $error("grant level differs from source level");
	chk_grant_above: assert property (grant.valid
		|-> ($past(inService) >> grant.level) == 4'h0)
		else $error("grant not above running level");
	chk_enter_set: assert property (svc.enter && svc.vec < 4'hb
		|=> inService[2'($past(srcLevels) >> (2 * $past(svc.vec)))])
		else $error("service entry not recorded");
	chk_leave_pop: assert property (svc.leave && !svc.enter && inService != 4'h0
		|=> $countones(inService) == $countones($past(inService)) - 1)
		else $error("return did not drop one level");
	cover property (grant.valid && grant.level == 2'h3);
	cover property (svc.enter);
	cover property (svc.leave && inService != 4'h0);
endmodule
bind ipef_top ipef_top_sva u_sva (.sys_clk, .resetn, .hsel, .haddr, .htrans, .hwrite,
	.hready, .hreadyout, .hresp, .hrdata, .ext2_prio_lo, .ext3_prio_lo, .svc, .grant,
	.srcLevels, .inService);

// >>> tb_top.sv
`timescale 1ns/10ps
module tb_top;
	localparam int MC = 2;
	localparam logic [7:0] CTRL = ipef_pkg::TIMER_EXTIRQ_CONTROL_IDX;
	localparam logic [7:0] IDX [4] = '{ipef_pkg::SOURCE_PRIO_LOW_IDX,
		ipef_pkg::SOURCE_PRIO_HIGH_IDX, ipef_pkg::EXTRA_PRIO_LOW_IDX,
		ipef_pkg::EXTRA_PRIO_HIGH_IDX};
	localparam logic [7:0] MASK [4] = '{8'h3f, 8'hff, 8'h07, 8'h07};
	logic sys_clk, resetn, hsel, hwrite, hreadyout, hresp, ack;
	logic [31:0] haddr, hwdata, hrdata, rd, wd;
	logic [1:0] htrans;
	logic ext_irq_zero_pin, ext_irq_one_pin, ext2_prio_lo, ext3_prio_lo;
	logic [10:0] srcPending;
	logic [21:0] lvl;
	logic [3:0] insvc;
	ipef_pkg::ipef_svc_s svc;
	ipef_pkg::ipef_grant_s grant;
	logic [7:0] mirror [4];
	logic [3:0] order [$];
	int n_mismatch, compares, seed;
	ipef_top #(.MC_DIV(MC)) uut (.sys_clk, .resetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.ext_irq_zero_pin, .ext_irq_one_pin, .ext2_prio_lo, .ext3_prio_lo, .srcPending,
		.svc, .grant, .srcLevels(lvl), .inService(insvc));
	ipef_core_model u_core (.sys_clk, .resetn, .grant, .ack, .svc);
	// clock and a watchdog sized well past the whole sequence
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	initial
	begin
		#200000;
		n_mismatch++;
		summarize();
	end
	// record which vector the core enters, in order
	always @(posedge sys_clk)
		if (svc.enter === 1'b1)
			order.push_back(svc.vec);
	task automatic summarize();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// single AHB-Lite transfer; no wait count assumed, the watchdog ends a hang
	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] d);
		@(posedge sys_clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {22'h0, idx, 2'b00};
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rdchk(input string name, input logic [7:0] idx, input logic [31:0] exp);
		xfer(1'b0, idx, 32'h0);
		chk(name, rd, exp);
	endtask
	// both pins fall and rise again, each level held well over a machine cycle
	task automatic fall();
		ext_irq_zero_pin <= 1'b0;
		ext_irq_one_pin <= 1'b0;
		repeat (3 * MC) @(posedge sys_clk);
		ext_irq_zero_pin <= 1'b1;
		ext_irq_one_pin <= 1'b1;
		repeat (3 * MC) @(posedge sys_clk);
	endtask
	function automatic logic [21:0] expLvl();
		logic [7:0] l, h, xl, xh;
		l = mirror[0];
		h = mirror[1];
		xl = mirror[2];
		xh = mirror[3];
		return {xh[2], xl[2], xh[1], xl[1], xh[0], xl[0], h[7], ext3_prio_lo, h[6],
			ext2_prio_lo, h[5], l[5], h[4], l[4], h[3], l[3], h[2], l[2], h[1], l[1],
			h[0], l[0]};
	endfunction
	initial
	begin
		seed = 83;
		{hsel, hwrite, htrans, haddr, hwdata, ack, srcPending} = '0;
		{ext_irq_zero_pin, ext_irq_one_pin, ext2_prio_lo, ext3_prio_lo} = 4'hc;
		resetn = 1'b0;
		repeat (5) @(posedge sys_clk);
		resetn <= 1'b1;
		for (int i = 0; i < 4; i++)
			rdchk("prio reset", IDX[i], 32'h0);
		rdchk("ctrl reset", CTRL, 32'h0);
		// random settings: read back masked and compare the derived levels
		repeat (6)
		begin
			for (int i = 0; i < 4; i++)
			begin
				wd = $random(seed);
				xfer(1'b1, IDX[i], wd);
				mirror[i] = wd[7:0] & MASK[i];
			end
			{ext2_prio_lo, ext3_prio_lo} <= 2'($random(seed));
			srcPending <= 11'($random(seed)) & 11'h7fa;
			for (int i = 0; i < 4; i++)
				rdchk("prio reg", IDX[i], {24'h0, mirror[i]});
			chk("levels", {10'h0, lvl}, {10'h0, expLvl()});
		end
		srcPending <= '0;
		xfer(1'b1, 8'h89, 32'hff);
		rdchk("unmapped", 8'h89, 32'h0);
		// level mode follows the inverted pins and ignores software writes
		ext_irq_zero_pin <= 1'b0;
		ext_irq_one_pin <= 1'b0;
		xfer(1'b1, CTRL, 32'h0);
		rdchk("level low", CTRL, 32'h0a);
		ext_irq_zero_pin <= 1'b1;
		ext_irq_one_pin <= 1'b1;
		// a software write of both flags in level mode must not stick
		xfer(1'b1, CTRL, 32'h0a);
		rdchk("level high", CTRL, 32'h0);
		// edge mode: equal levels, then external 1 raised above external 0
		for (int k = 0; k < 2; k++)
		begin
			xfer(1'b1, IDX[0], 32'h0);
			xfer(1'b1, IDX[1], k ? 32'h04 : 32'h00);
			xfer(1'b1, CTRL, 32'h05);
			fall();
			rdchk("edge latch", CTRL, 32'h0f);
			if (k == 0)
			begin
				xfer(1'b1, CTRL, 32'h05);
				rdchk("sw clear", CTRL, 32'h05);
				fall();
			end
			order.delete();
			ack <= 1'b1;
			for (int t = 0; t < 100 && order.size() < 2; t++)
				@(posedge sys_clk);
			ack <= 1'b0;
			chk("service order", {order[0], order[1]}, k ? 8'h20 : 8'h02);
			repeat (12) @(posedge sys_clk);
			rdchk("entry clear", CTRL, 32'h05);
		end
		summarize();
	end
endmodule
